// >>> rtl/fsp_map.svh
// Address map, field positions, command codes and timing constants of the protection block.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define FSP_OFS_CMD      8'h00
`define FSP_OFS_PW_LO    8'h04
`define FSP_OFS_PW_HI    8'h08
`define FSP_OFS_STATUS   8'h0C
`define FSP_OFS_PERSIST  8'h10
`define FSP_OFS_DYNAMIC  8'h14

// ----------------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------------
`define FSP_OPC_LSB      0
`define FSP_OPC_MSB      3
`define FSP_SEC_LSB      8
`define FSP_MS_PER_BIT   16
`define FSP_MS_PW_BIT    17

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define FSP_OPC_PPB_PROG   4'h1
`define FSP_OPC_PPB_ERASE  4'h2
`define FSP_OPC_FREEZE_SET 4'h3
`define FSP_OPC_DYB_SET    4'h4
`define FSP_OPC_DYB_CLR    4'h5
`define FSP_OPC_MODE_SEL   4'h6
`define FSP_OPC_PW_PROG    4'h7
`define FSP_OPC_PW_UNLOCK  4'h8

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define FSP_ST_BUSY      0
`define FSP_ST_REJECT    1
`define FSP_ST_FREEZE    2
`define FSP_ST_PER_SEL   3
`define FSP_ST_PW_SEL    4
`define FSP_ST_WP_LOW    5
`define FSP_ST_VFY_FAIL  6

// ----------------------------------------------------------------------------
// Widths, reset values and timing
// ----------------------------------------------------------------------------
`define FSP_SEC_BITS     8
`define FSP_CNT_BITS     16
`define FSP_BIT_ERASED   1'b1
`define FSP_BIT_PROGRAM  1'b0
`define FSP_PW_CHECK_NS  1000
`define FSP_CLK_MHZ      200
`define FSP_PW_CHECK_CYC ((`FSP_PW_CHECK_NS * `FSP_CLK_MHZ) / 1000)

`endif

// >>> rtl/fsp_pkg.sv
// Types shared by the sector protection block and its users.
`include "fsp_map.svh"

package fsp_pkg;

	// ------------------------------------------------------------------------
	// Array program or erase request and its answer
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic                       valid;
		logic                       erase;
		logic [`FSP_SEC_BITS-1:0]   sector;
	} fsp_op_type;

	typedef struct packed {
		logic                       ok;
		logic                       blocked;
		logic                       erase;
	} fsp_res_type;

	// ------------------------------------------------------------------------
	// Internal sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		FSP_IDLE,
		FSP_PREPROG,
		FSP_ERASE,
		FSP_VERIFY,
		FSP_PWCHECK
	} fsp_state_type;

endpackage : fsp_pkg

// >>> rtl/fsp_sector_protect.sv
// Sector protection controller: mode selection, per-sector bits, freeze bit and write protect.
//
// Summary of operation
// - Persistent protection is the mode until a mode-selection bit gets programmed.
// - A programmed mode-selection bit is permanent; switching to the other mode is refused.
// - Requesting both mode-selection bits together aborts and changes neither.
// - Programmed persistent selection bit blocks programming the password selection bit.
// - In password mode the 64-bit password cannot be read or programmed.
// - Password selection bit cannot be erased and blocks the persistent selection bit.
// - Before password mode is chosen, password verify reads return the stored password.
// - Protected sectors refuse program and erase; unprotected sectors accept both.
// - Low write-protect pin blocks program and erase of the two outermost sectors.
// - Persistent locks stay fixed; dynamic locks toggle with one simple command.
// - One non-volatile persistent bit per sector survives power cycles.
// - Persistent bits program singly; one erase-all command clears them all.
// - Erase-all preprograms and verifies internally with no host timing.
// - One volatile freeze bit: 0 freezes persistent bits, 1 lets them change.
// - Freeze-set command locks; locked persistent bits refuse program and erase.
// - Only hardware reset or power-up releases the freeze bit in persistent mode.
// - Each sector has a dynamic bit; either bit at 0 protects the sector.
// - Blocked sector operations change nothing and the array returns to read mode.
// - Matching password unlock releases the freeze bit after a fixed 1 us compare.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_sector_protect #(
	parameter int SECTORS         = 32,
	parameter int PRE_CYC         = 64,
	parameter int ERS_CYC         = 256,
	parameter int VER_CYC         = 64,
	parameter bit DYB_PWRUP_CLEAR = 1'b1
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire logic                nv_blank_b,
	input  wire logic                wp_b,
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [31:0]         rd_data,
	input  fsp_pkg::fsp_op_type      op_in,
	output fsp_pkg::fsp_res_type     op_out
);

	localparam int SEC_W = (SECTORS > 1) ? $clog2(SECTORS) : 1;
	localparam int CNT_W = `FSP_CNT_BITS;
	localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(PRE_CYC - 1);
	localparam logic [CNT_W-1:0] ERS_LAST = CNT_W'(ERS_CYC - 1);
	localparam logic [CNT_W-1:0] VER_LAST = CNT_W'(VER_CYC - 1);
	localparam logic [CNT_W-1:0] PWC_LAST = CNT_W'(`FSP_PW_CHECK_CYC - 1);
	localparam logic [SEC_W-1:0] SEC_TOP  = SEC_W'(SECTORS - 1);
	localparam logic [SEC_W-1:0] SEC_BOT  = '0;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// One-hot select of a sector; used by every single-bit update.
	function automatic logic [SECTORS-1:0] fsp_sel(input logic [SEC_W-1:0] s);
		logic [SECTORS-1:0] v;
		v    = '0;
		v[s] = 1'b1;
		return v;
	endfunction : fsp_sel

	// ------------------------------------------------------------------------
	// Reset and pin synchronisers
	// ------------------------------------------------------------------------
	logic                       rst_meta_reg;
	logic                       rst_sync_reg;
	logic                       nv_meta_reg;
	logic                       nv_sync_reg;
	logic                       wp_meta_reg;
	logic                       wp_sync_reg;

	// Hardware reset release; assertion is immediate, release waits two edges.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Blank-array initialisation of the non-volatile store; not a power cycle.
	always_ff @(posedge ref_clk or negedge nv_blank_b)
	begin
		if (!nv_blank_b)
		begin
			nv_meta_reg <= 1'b0;
			nv_sync_reg <= 1'b0;
		end
		else
		begin
			nv_meta_reg <= 1'b1;
			nv_sync_reg <= nv_meta_reg;
		end
	end

	// Write-protect pin comes from outside, so it passes two flops first.
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			wp_meta_reg <= 1'b1;
			wp_sync_reg <= 1'b1;
		end
		else
		begin
			wp_meta_reg <= wp_b;
			wp_sync_reg <= wp_meta_reg;
		end
	end

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [SECTORS-1:0]         ppb_reg;
	logic [SECTORS-1:0]         ppb_next;
	logic                       per_bit_reg;
	logic                       pw_bit_reg;
	logic [63:0]                password_reg;
	logic [SECTORS-1:0]         dyb_reg;
	logic [SECTORS-1:0]         dyb_next;
	logic                       freeze_reg;
	logic                       freeze_next;
	logic                       init_done_reg;
	logic [63:0]                pw_stage_reg;
	fsp_pkg::fsp_state_type     state_reg;
	fsp_pkg::fsp_state_type     state_next;
	logic [CNT_W-1:0]           cnt_reg;
	logic [CNT_W-1:0]           cnt_next;
	logic                       reject_reg;
	logic                       vfy_fail_reg;
	logic [31:0]                rd_data_reg;
	fsp_pkg::fsp_res_type       op_out_reg;

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	wire                        wr_cmd     = wr_en && (addr == `FSP_OFS_CMD);
	wire [3:0]                  opc        = wr_data[`FSP_OPC_MSB:`FSP_OPC_LSB];
	wire [SEC_W-1:0]            cmd_sec    = wr_data[`FSP_SEC_LSB +: SEC_W];
	wire                        ms_per     = wr_data[`FSP_MS_PER_BIT];
	wire                        ms_pw      = wr_data[`FSP_MS_PW_BIT];
	wire                        idle       = (state_reg == fsp_pkg::FSP_IDLE) && init_done_reg;
	wire                        cnt_zero   = (cnt_reg == '0);
	wire                        pw_mode    = (pw_bit_reg == `FSP_BIT_PROGRAM);
	wire                        per_sel    = (per_bit_reg == `FSP_BIT_PROGRAM);
	wire                        unlocked   = (freeze_reg == `FSP_BIT_ERASED);
	wire                        sec_in     = (SEC_W'(cmd_sec) <= SEC_TOP);

	wire                        ms_ok      = !(ms_per && ms_pw) && (ms_per || ms_pw)
	                                         && !(ms_pw && per_sel) && !(ms_per && pw_mode);

	wire                        cmd_legal  =
		(opc == `FSP_OPC_PPB_PROG)   ? (unlocked && sec_in) :
		(opc == `FSP_OPC_PPB_ERASE)  ? unlocked :
		(opc == `FSP_OPC_FREEZE_SET) ? 1'b1 :
		(opc == `FSP_OPC_DYB_SET)    ? sec_in :
		(opc == `FSP_OPC_DYB_CLR)    ? sec_in :
		(opc == `FSP_OPC_MODE_SEL)   ? ms_ok :
		(opc == `FSP_OPC_PW_PROG)    ? !pw_mode :
		(opc == `FSP_OPC_PW_UNLOCK)  ? pw_mode : 1'b0;

	wire                        cmd_ok     = wr_cmd && idle && cmd_legal;
	wire                        cmd_rej    = wr_cmd && !(idle && cmd_legal);
	wire                        do_op      = cmd_ok;
	wire                        ppb_prog   = do_op && (opc == `FSP_OPC_PPB_PROG);
	wire                        ppb_erase  = do_op && (opc == `FSP_OPC_PPB_ERASE);
	wire                        pw_prog    = do_op && (opc == `FSP_OPC_PW_PROG);
	wire                        pw_unlock  = do_op && (opc == `FSP_OPC_PW_UNLOCK);
	wire                        ms_write   = do_op && (opc == `FSP_OPC_MODE_SEL);
	wire                        ers_end    = (state_reg == fsp_pkg::FSP_ERASE) && cnt_zero;
	wire                        vfy_end    = (state_reg == fsp_pkg::FSP_VERIFY) && cnt_zero;
	wire                        pwc_end    = (state_reg == fsp_pkg::FSP_PWCHECK) && cnt_zero;
	wire                        pw_match   = (pw_stage_reg == password_reg);

	// ------------------------------------------------------------------------
	// Erase-all and password-compare sequencer
	// ------------------------------------------------------------------------

	// Erase-all runs preprogram, erase and verify on its own counts so the host
	// only polls busy; the password compare holds busy for a fixed time, which
	// slows brute-force guessing.
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_zero ? cnt_reg : cnt_reg - CNT_W'(1);
		case (state_reg)
			fsp_pkg::FSP_IDLE:
			begin
				if (ppb_erase)
				begin
					state_next = fsp_pkg::FSP_PREPROG;
					cnt_next   = PRE_LAST;
				end
				else if (pw_unlock)
				begin
					state_next = fsp_pkg::FSP_PWCHECK;
					cnt_next   = PWC_LAST;
				end
			end
			fsp_pkg::FSP_PREPROG:
			begin
				if (cnt_zero)
				begin
					state_next = fsp_pkg::FSP_ERASE;
					cnt_next   = ERS_LAST;
				end
			end
			fsp_pkg::FSP_ERASE:
			begin
				if (cnt_zero)
				begin
					state_next = fsp_pkg::FSP_VERIFY;
					cnt_next   = VER_LAST;
				end
			end
			fsp_pkg::FSP_VERIFY:
			begin
				if (cnt_zero)
					state_next = fsp_pkg::FSP_IDLE;
			end
			fsp_pkg::FSP_PWCHECK:
			begin
				if (cnt_zero)
					state_next = fsp_pkg::FSP_IDLE;
			end
			default:
			begin
				state_next = fsp_pkg::FSP_IDLE;
				cnt_next   = '0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Next values of the protection bits
	// ------------------------------------------------------------------------
	always_comb
	begin
		ppb_next = ppb_reg;
		if (ppb_prog)
			ppb_next = ppb_reg & ~fsp_sel(cmd_sec);
		if (ppb_erase)
			ppb_next = '0;
		if (ers_end)
			ppb_next = '1;
	end

	always_comb
	begin
		dyb_next = dyb_reg;
		if (do_op && (opc == `FSP_OPC_DYB_SET))
			dyb_next = dyb_reg & ~fsp_sel(cmd_sec);
		if (do_op && (opc == `FSP_OPC_DYB_CLR))
			dyb_next = dyb_reg | fsp_sel(cmd_sec);
	end

	always_comb
	begin
		freeze_next = freeze_reg;
		if (!init_done_reg)
			freeze_next = pw_mode ? `FSP_BIT_PROGRAM : `FSP_BIT_ERASED;
		else if (do_op && (opc == `FSP_OPC_FREEZE_SET))
			freeze_next = `FSP_BIT_PROGRAM;
		else if (pwc_end && pw_match)
			freeze_next = `FSP_BIT_ERASED;
	end

	// ------------------------------------------------------------------------
	// Non-volatile store
	// ------------------------------------------------------------------------

	// survives hardware reset
	// Only the blank-array input resets these, so a hardware reset or a power
	// cycle of the logic never disturbs them.
	always_ff @(posedge ref_clk or negedge nv_sync_reg)
	begin
		if (!nv_sync_reg)
		begin
			ppb_reg      <= '1;
			per_bit_reg  <= `FSP_BIT_ERASED;
			pw_bit_reg   <= `FSP_BIT_ERASED;
			password_reg <= '1;
		end
		else
		begin
			ppb_reg      <= ppb_next;
			if (ms_write && ms_per)
				per_bit_reg <= `FSP_BIT_PROGRAM;
			if (ms_write && ms_pw)
				pw_bit_reg  <= `FSP_BIT_PROGRAM;
			if (pw_prog)
				password_reg <= password_reg & pw_stage_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Volatile state
	// ------------------------------------------------------------------------

	// The freeze bit starts erased; in the first cycle after release it takes
	// the locked value when password mode is programmed.
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			dyb_reg       <= DYB_PWRUP_CLEAR ? '1 : '0;
			freeze_reg    <= `FSP_BIT_ERASED;
			init_done_reg <= 1'b0;
			state_reg     <= fsp_pkg::FSP_IDLE;
			cnt_reg       <= '0;
		end
		else
		begin
			dyb_reg       <= dyb_next;
			freeze_reg    <= freeze_next;
			init_done_reg <= 1'b1;
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
		end
	end

	// Staging words for password program and unlock, plus result flags.
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
		begin
			pw_stage_reg <= '1;
			reject_reg   <= 1'b0;
			vfy_fail_reg <= 1'b0;
		end
		else
		begin
			if (wr_en && (addr == `FSP_OFS_PW_LO))
				pw_stage_reg[31:0]  <= wr_data;
			if (wr_en && (addr == `FSP_OFS_PW_HI))
				pw_stage_reg[63:32] <= wr_data;
			if (cmd_rej || cmd_ok)
				reject_reg <= cmd_rej;
			if (vfy_end)
				vfy_fail_reg <= (ppb_reg != '1);
		end
	end

	// ------------------------------------------------------------------------
	// Array program and erase gate
	// ------------------------------------------------------------------------
	wire [SEC_W-1:0]            op_sec     = op_in.sector[SEC_W-1:0];
	wire                        op_in_rng  = (op_in.sector <= `FSP_SEC_BITS'(SECTORS - 1));
	wire                        wp_low     = !wp_sync_reg;
	wire                        wp_hit     = wp_low && ((op_sec == SEC_BOT) || (op_sec == SEC_TOP));
	wire                        sec_prot   = !ppb_reg[op_sec] || !dyb_reg[op_sec];
	wire                        op_block   = !op_in_rng || sec_prot || wp_hit;

	// blocked means no change
	// A blocked answer carries no write to the array; the array control treats
	// it as the end of the command and goes back to reading.
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			op_out_reg <= '0;
		else
		begin
			op_out_reg.ok      <= op_in.valid && !op_block;
			op_out_reg.blocked <= op_in.valid && op_block;
			op_out_reg.erase   <= op_in.valid && op_in.erase;
		end
	end

	// ------------------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------------------
	wire [31:0]                 status_w   = 32'(
		{ vfy_fail_reg, wp_low, pw_mode, per_sel, freeze_reg, reject_reg, !idle }
	);
	wire [31:0]                 rd_mux     =
		(addr == `FSP_OFS_STATUS)  ? status_w :
		(addr == `FSP_OFS_PERSIST) ? 32'(ppb_reg) :
		(addr == `FSP_OFS_DYNAMIC) ? 32'(dyb_reg) :
		(addr == `FSP_OFS_PW_LO)   ? (pw_mode ? 32'h0000_0000 : password_reg[31:0]) :
		(addr == `FSP_OFS_PW_HI)   ? (pw_mode ? 32'h0000_0000 : password_reg[63:32]) :
		32'h0000_0000;

	// Read data stand in the cycle after each cycle with rd_en high, and are zero otherwise.
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			rd_data_reg <= '0;
		else
			rd_data_reg <= rd_en ? rd_mux : 32'h0000_0000;
	end

	assign rd_data = rd_data_reg;
	assign op_out  = op_out_reg;

endmodule : fsp_sector_protect

// >>> test/fsp_sector_protect_asserts.sv
// Port-level checker for the sector protection block, bound into its top module.
`timescale 1ns/1ps

module fsp_sector_protect_asserts #(
	parameter int SECTORS = 32
) (
	input  wire logic           ref_clk,
	input  wire logic           rst_b,
	input  wire logic           nv_blank_b,
	input  wire logic           wp_b,
	input  wire logic [7:0]     addr,
	input  wire logic [31:0]    wr_data,
	input  wire logic           wr_en,
	input  wire logic           rd_en,
	input  wire logic [31:0]    rd_data,
	input  fsp_pkg::fsp_op_type  op_in,
	input  fsp_pkg::fsp_res_type op_out
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [2:0] rdy_reg;
	logic       st_rd_reg;
	logic       pw_rd_reg;
	logic       frz_lo_reg;
	logic [1:0] mode_seen_reg;

	// Waits out the synchroniser and init cycle, when outputs still read as zero.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdy_reg    <= 3'h0;
			st_rd_reg  <= 1'b0;
			pw_rd_reg  <= 1'b0;
			frz_lo_reg <= 1'b0;
		end
		else
		begin
			rdy_reg    <= (rdy_reg == 3'h4) ? rdy_reg : rdy_reg + 3'h1;
			st_rd_reg  <= rd_en && addr == 8'h0C;
			pw_rd_reg  <= rd_en && (addr == 8'h04 || addr == 8'h08);
			frz_lo_reg <= frz_lo_reg || (st_rd_reg && !rd_data[2] && !rd_data[4]);
		end
	end

	// Mode bits are non-volatile, so only a blank store forgets them.
	always_ff @(posedge ref_clk or negedge nv_blank_b)
	begin
		if (!nv_blank_b)
			mode_seen_reg <= 2'h0;
		else if (st_rd_reg && rdy_reg == 3'h4)
			mode_seen_reg <= mode_seen_reg | rd_data[4:3];
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b || rdy_reg != 3'h4);

	sequence s_wp_held;
		!wp_b [*4];
	endsequence
	sequence s_outer_op;
		op_in.valid && (op_in.sector == 8'h00 || op_in.sector == SECTORS - 1);
	endsequence

	a_one_answer: assert property (op_in.valid |=> op_out.ok ^ op_out.blocked)
		else $error("request without exactly one answer");
	a_no_stray: assert property (!op_in.valid |=> !op_out.ok && !op_out.blocked)
		else $error("answer without a request");
	a_kind_echo: assert property (op_in.valid |=> op_out.erase == $past(op_in.erase))
		else $error("answer kind differs from request");
	a_wp_outer: assert property (s_wp_held ##0 s_outer_op |=> op_out.blocked)
		else $error("outer sector open under write protect");
	a_range_block: assert property (op_in.valid && op_in.sector >= SECTORS |=> op_out.blocked)
		else $error("missing sector not blocked");
	a_freeze_kept: assert property (st_rd_reg && frz_lo_reg |-> !rd_data[2])
		else $error("freeze released without reset");
	a_mode_kept: assert property (st_rd_reg |-> (rd_data[4:3] & mode_seen_reg) == mode_seen_reg)
		else $error("selected mode was lost");
	a_pw_hidden: assert property (pw_rd_reg && mode_seen_reg[1] |-> rd_data == 32'h0)
		else $error("password visible in password mode");
endmodule : fsp_sector_protect_asserts

bind fsp_sector_protect fsp_sector_protect_asserts #(.SECTORS(SECTORS)) u_chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .nv_blank_b(nv_blank_b), .wp_b(wp_b),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .op_in(op_in), .op_out(op_out)
);

// >>> test/fsp_host_model.sv
// Host model that turns bench requests into array program or erase cycles.
`timescale 1ns/1ps

module fsp_host_model (
	input  wire logic            ref_clk,
	input  wire logic            req,
	input  wire logic            req_erase,
	input  wire logic [7:0]      req_sec,
	output fsp_pkg::fsp_op_type  op_in,
	input  fsp_pkg::fsp_res_type op_out,
	output logic                 got,
	output logic                 blk
);
	initial op_in = '0;

	// One-cycle requests; idle fields flip so a stale value never passes for a new one.
	always @(posedge ref_clk)
	begin
		op_in.valid  <= req;
		op_in.erase  <= req ? req_erase : !op_in.erase;
		op_in.sector <= req ? req_sec : ~op_in.sector;
		got          <= op_out.ok || op_out.blocked;
		blk          <= op_out.blocked;
	end
endmodule : fsp_host_model

// >>> test/fsp_sector_protect_tb.sv
// Self-checking bench for the sector protection block.
`timescale 1ns/1ps

module fsp_sector_protect_tb;
	localparam int SECTORS = 32;
	logic                 ref_clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 nv_blank_b = 1'b0;
	logic                 wp_b = 1'b1;
	logic [7:0]           addr = 8'h00;
	logic [31:0]          wr_data = 32'h0;
	logic                 wr_en = 1'b0;
	logic                 rd_en = 1'b0;
	logic [31:0]          rd_data;
	logic                 req = 1'b0;
	logic                 req_erase = 1'b0;
	logic [7:0]           req_sec = 8'h00;
	logic                 got;
	logic                 blk;
	fsp_pkg::fsp_op_type  op_in;
	fsp_pkg::fsp_res_type op_out;
	int                   err_total = 0;
	int                   total_checks = 0;
	logic [15:0]          lfsr = 16'h07FE;
	logic [31:0]          pw_lo;
	logic [31:0]          pw_hi;
	logic [31:0]          v;
	logic [7:0]           s;
	logic [7:0]           t;

	// Short erase phases keep the run brief; expectations do not depend on them.
	fsp_sector_protect #(.SECTORS(SECTORS), .PRE_CYC(2), .ERS_CYC(2), .VER_CYC(2)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .nv_blank_b(nv_blank_b), .wp_b(wp_b),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .op_in(op_in), .op_out(op_out));
	fsp_host_model u_host (.ref_clk(ref_clk), .req(req), .req_erase(req_erase),
		.req_sec(req_sec), .op_in(op_in), .op_out(op_out), .got(got), .blk(blk));

	// Clock of 5 ns period.
	always #2.5 ref_clk = !ref_clk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next
	// Idle status word; f is {password, persistent, freeze, rejected}.
	function automatic logic [31:0] stat(input logic [3:0] f);
		return {27'h0, f, 1'b0};
	endfunction : stat
	function automatic logic [31:0] one_clr(input logic [7:0] n);
		return ~(32'h1 << n);
	endfunction : one_clr

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
		if (a != 8'h0C)
			chk(v, e);
	endtask : rdchk
	// Polls status until idle, bounded, then compares the final status word.
	task automatic cmdchk(input logic [31:0] c, input logic [31:0] e);
		int n;
		wr(8'h00, c);
		n = 0;
		do
		begin
			rdchk(8'h0C, e);
			n++;
		end
		while (v[0] && n < 1000);
		chk(v, e);
	endtask : cmdchk
	task automatic op(input logic e, input logic [7:0] sec, input logic b);
		int n;
		@(posedge ref_clk);
		req <= 1'b1;
		req_erase <= e;
		req_sec <= sec;
		@(posedge ref_clk);
		req <= 1'b0;
		n = 0;
		while (got !== 1'b1 && n < 8)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk({30'h0, got, blk}, {30'h0, 1'b1, b});
	endtask : op
	task automatic do_reset(input logic blank);
		rst_b <= 1'b0;
		nv_blank_b <= !blank;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		nv_blank_b <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask : do_reset

	// Main sequence.
	initial
	begin
		do_reset(1'b1);
		lfsr = lfsr_next(lfsr);
		pw_lo = {lfsr, ~lfsr};
		lfsr = lfsr_next(lfsr);
		pw_hi = {lfsr, lfsr ^ 16'h5A5A};
		s = 8'h01 + lfsr[7:0] % 8'h1E;
		t = 8'h1F - s;
		cmdchk(32'h0, stat(4'h3));
		rdchk(8'h10, 32'hFFFFFFFF);
		rdchk(8'h14, 32'hFFFFFFFF);
		cmdchk(32'h00030006, stat(4'h3));
		wr(8'h04, pw_lo);
		wr(8'h08, pw_hi);
		cmdchk(32'h00000007, stat(4'h2));
		rdchk(8'h04, pw_lo);
		rdchk(8'h08, pw_hi);
		$display("test mode and password done");
		cmdchk({16'h0, s, 8'h01}, stat(4'h2));
		rdchk(8'h10, one_clr(s));
		op(1'b0, s, 1'b1);
		op(1'b1, t, 1'b0);
		op(1'b0, 8'h28, 1'b1);
		cmdchk({16'h0, t, 8'h04}, stat(4'h2));
		op(1'b1, t, 1'b1);
		cmdchk({16'h0, t, 8'h05}, stat(4'h2));
		op(1'b0, t, 1'b0);
		cmdchk(32'h00000002, stat(4'h2));
		rdchk(8'h10, 32'hFFFFFFFF);
		op(1'b1, s, 1'b0);
		$display("test sector bits done");
		wp_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		op(1'b0, 8'h00, 1'b1);
		op(1'b1, 8'h1F, 1'b1);
		op(1'b0, s, 1'b0);
		wp_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		$display("test write protect done");
		cmdchk({16'h0, s, 8'h01}, stat(4'h2));
		cmdchk(32'h00000003, stat(4'h0));
		cmdchk({16'h0, t, 8'h01}, stat(4'h1));
		cmdchk(32'h00000002, stat(4'h1));
		rdchk(8'h10, one_clr(s));
		do_reset(1'b0);
		cmdchk(32'h0, stat(4'h3));
		rdchk(8'h10, one_clr(s));
		op(1'b1, s, 1'b1);
		$display("test freeze done");
		cmdchk(32'h00020006, stat(4'hA));
		rdchk(8'h04, 32'h0);
		cmdchk(32'h00000007, stat(4'hB));
		cmdchk(32'h00010006, stat(4'hB));
		do_reset(1'b0);
		wr(8'h08, pw_hi);
		wr(8'h04, ~pw_lo);
		cmdchk(32'h00000008, stat(4'h8));
		wr(8'h04, pw_lo);
		cmdchk(32'h00000008, stat(4'hA));
		$display("test password mode done");
		do_reset(1'b1);
		cmdchk(32'h00010006, stat(4'h6));
		cmdchk(32'h00020006, stat(4'h7));
		$display("test persistent lock done");
		tally_and_finish();
	end

	// Watchdog; the tests need under a thousand cycles.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end
endmodule : fsp_sector_protect_tb
